// >>> logic/tsci_regs.svh
// Notes on behaviour
// - each input group shares one rate for A and B, one of four rates
// - at the top input rate the B input of that group is ignored
// - each output group has its own rate, independent of input groups
// - at the top output rate the B output is unused and tristated
// - every input and output group may carry inverted data
// - the two select pins give the master clock rate code 0 to 3
// - active master clock edge is rising or falling by a setting
// - the 8 kHz frame pulse marks the frame boundary of all streams
// - input frame pulse may be active high or active low
// - two output clocks, each with its own programmable frequency
// - each output clock may be inverted on its own
// - each output clock comes from master clock or system clock
// - two frame pulse outputs, one companion clock period wide
// - each output frame pulse has its own programmable active level
// - gate pin low tristates all serial outputs
// - 32 input groups and 32 output groups, each holding A and B
`ifndef TSCI_REGS_SVH
`define TSCI_REGS_SVH

`define TSCI_GROUPS 32
`define TSCI_CNT_W 13
`define TSCI_PAGE_IN 3'h0
`define TSCI_PAGE_OUT 3'h1
`define TSCI_REG_ICLK 8'h40
`define TSCI_REG_OCLK 8'h41
`define TSCI_REG_STAT 8'h42

`define TSCI_F_RATE 1:0
`define TSCI_F_CFG 2:0
`define TSCI_F_INV 2
`define TSCI_F_TXA 15:8
`define TSCI_F_TXB 23:16
`define TSCI_F_FALL 0
`define TSCI_F_FPLOW 1
`define TSCI_F_ICLK 1:0
`define TSCI_F_OC0 4:0
`define TSCI_F_OC1 12:8
`define TSCI_OC_FALL 2
`define TSCI_OC_INT 3
`define TSCI_OC_FPLOW 4
`define TSCI_S_FRAME 2
`define TSCI_S_OVR 3

`define TSCI_RATE_FAST 2'h3
`define TSCI_BYTE_LAST 3'h7
`define TSCI_FPO_HALVES 2'h2
`define TSCI_STATE_RST '0

`endif

// >>> logic/tsci_pkg.sv
`include "tsci_regs.svh"
package tsci_pkg;

    typedef struct packed {
        logic [4:0] group;
        logic [7:0] byte_b;
        logic [7:0] byte_a;
    } tsci_rx_word_type;

    typedef struct packed {
        logic v0;
        logic v1;
        tsci_rx_word_type d0;
        tsci_rx_word_type d1;
    } tsci_buf_state_type;

    typedef struct packed {
        logic [2:0] ck_s;
        logic [1:0] fp_s;
        logic [3:0] sel_s;
        logic [1:0] gate_s;
        logic [1:0][`TSCI_GROUPS-1:0] ina_s;
        logic [1:0][`TSCI_GROUPS-1:0] inb_s;
        logic [`TSCI_CNT_W-1:0] edge_cnt;
        logic [`TSCI_GROUPS-1:0][2:0] in_cfg;
        logic [`TSCI_GROUPS-1:0][2:0] in_act;
        logic [`TSCI_GROUPS-1:0][2:0] out_cfg;
        logic [`TSCI_GROUPS-1:0][2:0] out_act;
        logic [`TSCI_GROUPS-1:0][7:0] tx_a;
        logic [`TSCI_GROUPS-1:0][7:0] tx_b;
        logic [`TSCI_GROUPS-1:0][7:0] lat_a;
        logic [`TSCI_GROUPS-1:0][7:0] lat_b;
        logic [`TSCI_GROUPS-1:0][7:0] sr_a;
        logic [`TSCI_GROUPS-1:0][7:0] sr_b;
        logic [`TSCI_GROUPS-1:0][7:0] hold_a;
        logic [`TSCI_GROUPS-1:0][7:0] hold_b;
        logic [`TSCI_GROUPS-1:0] pending;
        logic [`TSCI_GROUPS-1:0] oa;
        logic [`TSCI_GROUPS-1:0] ob;
        logic [`TSCI_GROUPS-1:0] oe_a;
        logic [`TSCI_GROUPS-1:0] oe_b;
        logic [1:0] in_clk_sh;
        logic [1:0] in_clk_act;
        logic [1:0][4:0] ock_sh;
        logic [1:0][4:0] ock_act;
        logic [1:0] tclk;
        logic [1:0][2:0] tcnt;
        logic [1:0] fpo_act;
        logic [1:0][1:0] fpo_left;
        logic [1:0] ck_out;
        logic [1:0] fp_out;
        logic frame_seen;
        logic overrun;
        logic [31:0] rdata;
    } tsci_state_type;

endpackage : tsci_pkg

// >>> logic/tsci_skid_buf.sv
`timescale 1ns/1ps
`include "tsci_regs.svh"
module tsci_skid_buf
    import tsci_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input tsci_rx_word_type in_word,
    output logic out_valid,
    input wire logic out_ready,
    output tsci_rx_word_type out_word
);

    tsci_buf_state_type b;
    tsci_buf_state_type nxt_b;
    logic pop;
    logic take;

    // both sides come straight from flip-flops; the second entry
    // catches the word that arrives while the drain side stalls
    always_comb begin
        nxt_b = b;
        pop = b.v0 & out_ready;
        take = in_valid & ~b.v1;
        if (pop) begin
            if (b.v1) begin
                nxt_b.d0 = b.d1;
                nxt_b.v1 = 1'b0;
            end else begin
                nxt_b.v0 = 1'b0;
            end
        end
        if (take) begin
            if (!nxt_b.v0) begin
                nxt_b.d0 = in_word;
                nxt_b.v0 = 1'b1;
            end else begin
                nxt_b.d1 = in_word;
                nxt_b.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            b <= `TSCI_STATE_RST;
        end else begin
            b <= nxt_b;
        end
    end

    assign in_ready = ~b.v1;
    assign out_valid = b.v0;
    assign out_word = b.d0;

endmodule : tsci_skid_buf

// >>> logic/tsci_stream_core.sv
`timescale 1ns/1ps
`include "tsci_regs.svh"
module tsci_stream_core
    import tsci_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic master_tdm_clock_in,
    input wire logic master_frame_pulse_in,
    input wire logic [1:0] master_rate_select,
    input wire logic stream_output_gate,
    input wire logic [`TSCI_GROUPS-1:0] serial_in_primary,
    input wire logic [`TSCI_GROUPS-1:0] serial_in_secondary,
    output logic [`TSCI_GROUPS-1:0] serial_out_primary,
    output logic [`TSCI_GROUPS-1:0] serial_out_primary_oe,
    output logic [`TSCI_GROUPS-1:0] serial_out_secondary,
    output logic [`TSCI_GROUPS-1:0] serial_out_secondary_oe,
    output logic [1:0] timing_clock_out,
    output logic [1:0] timing_frame_pulse_out,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic rx_valid,
    input wire logic rx_ready,
    output tsci_rx_word_type rx_word
);

    tsci_state_type st;
    tsci_state_type nxt_st;
    logic push;
    logic push_ready;
    tsci_rx_word_type push_word;
    logic edge_now;
    logic frame_now;

    tsci_skid_buf u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(push_ready),
        .in_word(push_word),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_word(rx_word)
    );

    always_comb begin
        logic rise;
        logic fall;
        logic found;
        logic [1:0] cs;
        logic [1:0] ri;
        logic [1:0] ro;
        logic [1:0] sh;
        logic [1:0] fo;
        logic [2:0] bi;
        logic [2:0] e;
        logic [3:0] lim;
        logic [`TSCI_CNT_W-1:0] cur;
        logic [`TSCI_CNT_W-1:0] tmp;
        logic [7:0] sa;
        logic [7:0] sb;
        logic [4:0] idx;
        logic tick;
        rise = 1'b0;
        fall = 1'b0;
        found = 1'b0;
        cs = 2'h0;
        ri = 2'h0;
        ro = 2'h0;
        sh = 2'h0;
        fo = 2'h0;
        bi = 3'h0;
        e = 3'h0;
        lim = 4'h0;
        cur = '0;
        tmp = '0;
        sa = 8'h00;
        sb = 8'h00;
        idx = reg_addr[4:0];
        tick = 1'b0;
        nxt_st = st;
        push = 1'b0;
        push_word = '0;

        // pins pass two flip-flops; the third clock stage finds edges
        nxt_st.ck_s = {st.ck_s[1:0], master_tdm_clock_in};
        nxt_st.fp_s = {st.fp_s[0], master_frame_pulse_in};
        nxt_st.sel_s = {st.sel_s[1:0], master_rate_select};
        nxt_st.gate_s = {st.gate_s[0], stream_output_gate};
        nxt_st.ina_s = {st.ina_s[0], serial_in_primary};
        nxt_st.inb_s = {st.inb_s[0], serial_in_secondary};

        // register port; clears come first so hardware sets win
        nxt_st.rdata = 32'h0000_0000;
        if (reg_wr) begin
            if (reg_addr[7:5] == `TSCI_PAGE_IN) begin
                nxt_st.in_cfg[idx] = reg_wdata[`TSCI_F_CFG];
            end else if (reg_addr[7:5] == `TSCI_PAGE_OUT) begin
                nxt_st.out_cfg[idx] = reg_wdata[`TSCI_F_CFG];
                nxt_st.tx_a[idx] = reg_wdata[`TSCI_F_TXA];
                nxt_st.tx_b[idx] = reg_wdata[`TSCI_F_TXB];
            end else if (reg_addr == `TSCI_REG_ICLK) begin
                nxt_st.in_clk_sh = reg_wdata[`TSCI_F_ICLK];
            end else if (reg_addr == `TSCI_REG_OCLK) begin
                nxt_st.ock_sh[0] = reg_wdata[`TSCI_F_OC0];
                nxt_st.ock_sh[1] = reg_wdata[`TSCI_F_OC1];
            end else if (reg_addr == `TSCI_REG_STAT) begin
                if (reg_wdata[`TSCI_S_FRAME]) begin
                    nxt_st.frame_seen = 1'b0;
                end
                if (reg_wdata[`TSCI_S_OVR]) begin
                    nxt_st.overrun = 1'b0;
                end
            end
        end
        if (reg_rd) begin
            if (reg_addr[7:5] == `TSCI_PAGE_IN) begin
                nxt_st.rdata = {8'h00, st.hold_b[idx], st.hold_a[idx],
                    5'h00, st.in_cfg[idx]};
            end else if (reg_addr[7:5] == `TSCI_PAGE_OUT) begin
                nxt_st.rdata = {8'h00, st.tx_b[idx], st.tx_a[idx],
                    5'h00, st.out_cfg[idx]};
            end else if (reg_addr == `TSCI_REG_ICLK) begin
                nxt_st.rdata = {30'h0000_0000, st.in_clk_sh};
            end else if (reg_addr == `TSCI_REG_OCLK) begin
                nxt_st.rdata = {19'h0_0000, st.ock_sh[1], 3'h0,
                    st.ock_sh[0]};
            end else if (reg_addr == `TSCI_REG_STAT) begin
                nxt_st.rdata = {28'h000_0000, st.overrun,
                    st.frame_seen, st.sel_s[3:2]};
            end
        end

        // master timing
        rise = st.ck_s[1] & ~st.ck_s[2];
        fall = ~st.ck_s[1] & st.ck_s[2];
        edge_now = st.in_clk_act[`TSCI_F_FALL] ? fall : rise;
        frame_now = edge_now
            & (st.fp_s[1] ^ st.in_clk_act[`TSCI_F_FPLOW]);
        cs = st.sel_s[3:2];
        cur = frame_now ? '0 : st.edge_cnt;
        if (edge_now) begin
            nxt_st.edge_cnt = cur + `TSCI_CNT_W'(1);
        end
        // settings swap only at a frame so no frame is half-changed
        if (frame_now) begin
            nxt_st.in_act = st.in_cfg;
            nxt_st.out_act = st.out_cfg;
            nxt_st.in_clk_act = st.in_clk_sh;
            nxt_st.ock_act = st.ock_sh;
            nxt_st.frame_seen = 1'b1;
        end

        // hand the lowest pending group to the buffer
        if (push_ready) begin
            for (int g = 0; g < `TSCI_GROUPS; g++) begin
                if (st.pending[g] && !found) begin
                    found = 1'b1;
                    push = 1'b1;
                    push_word.group = 5'(g);
                    push_word.byte_a = st.hold_a[g];
                    push_word.byte_b = st.hold_b[g];
                    nxt_st.pending[g] = 1'b0;
                end
            end
        end

        // rates faster than the master clock are clamped to it
        for (int g = 0; g < `TSCI_GROUPS; g++) begin
            ri = nxt_st.in_act[g][`TSCI_F_RATE];
            sh = (cs >= ri) ? cs - ri : 2'h0;
            tmp = cur >> sh;
            bi = tmp[2:0];
            if (edge_now
                && ((cur & ((`TSCI_CNT_W'(1) << sh)
                - `TSCI_CNT_W'(1))) == '0)) begin
                sa = {st.sr_a[g][6:0],
                    st.ina_s[1][g] ^ nxt_st.in_act[g][`TSCI_F_INV]};
                sb = {st.sr_b[g][6:0],
                    st.inb_s[1][g] ^ nxt_st.in_act[g][`TSCI_F_INV]};
                nxt_st.sr_a[g] = sa;
                nxt_st.sr_b[g] = sb;
                if (bi == `TSCI_BYTE_LAST) begin
                    nxt_st.hold_a[g] = sa;
                    nxt_st.hold_b[g] =
                        (ri == `TSCI_RATE_FAST) ? 8'h00 : sb;
                    if (nxt_st.pending[g]) begin
                        nxt_st.overrun = 1'b1;
                    end
                    nxt_st.pending[g] = 1'b1;
                end
            end
            ro = nxt_st.out_act[g][`TSCI_F_RATE];
            sh = (cs >= ro) ? cs - ro : 2'h0;
            tmp = cur >> sh;
            bi = tmp[2:0];
            if (edge_now
                && ((cur & ((`TSCI_CNT_W'(1) << sh)
                - `TSCI_CNT_W'(1))) == '0)) begin
                if (bi == 3'h0) begin
                    nxt_st.lat_a[g] = st.tx_a[g];
                    nxt_st.lat_b[g] = st.tx_b[g];
                end
                nxt_st.oa[g] = nxt_st.lat_a[g][`TSCI_BYTE_LAST - bi]
                    ^ nxt_st.out_act[g][`TSCI_F_INV];
                nxt_st.ob[g] = nxt_st.lat_b[g][`TSCI_BYTE_LAST - bi]
                    ^ nxt_st.out_act[g][`TSCI_F_INV];
            end
            // enable follows the gate two flops behind the pin
            nxt_st.oe_a[g] = st.gate_s[1];
            nxt_st.oe_b[g] = st.gate_s[1]
                & (ro != `TSCI_RATE_FAST);
        end

        // output clocks and frame pulses
        for (int i = 0; i < 2; i++) begin
            fo = nxt_st.ock_act[i][`TSCI_F_RATE];
            if (nxt_st.ock_act[i][`TSCI_OC_INT]) begin
                tick = 1'b1;
                e = {1'b0, `TSCI_RATE_FAST - fo};
            end else begin
                tick = rise | fall;
                e = {1'b0, (cs >= fo) ? cs - fo : 2'h0};
            end
            lim = (4'h1 << e) - 4'h1;
            if (frame_now) begin
                nxt_st.tclk[i] = 1'b0;
                nxt_st.tcnt[i] = 3'h0;
                nxt_st.fpo_act[i] = 1'b1;
                nxt_st.fpo_left[i] = `TSCI_FPO_HALVES;
            end else if (tick) begin
                if ({1'b0, st.tcnt[i]} == lim) begin
                    nxt_st.tcnt[i] = 3'h0;
                    nxt_st.tclk[i] = ~st.tclk[i];
                    if (st.fpo_act[i]) begin
                        nxt_st.fpo_left[i] = st.fpo_left[i] - 2'h1;
                        if (st.fpo_left[i] == 2'h1) begin
                            nxt_st.fpo_act[i] = 1'b0;
                        end
                    end
                end else begin
                    nxt_st.tcnt[i] = st.tcnt[i] + 3'h1;
                end
            end
            nxt_st.ck_out[i] = nxt_st.tclk[i]
                ^ nxt_st.ock_act[i][`TSCI_OC_FALL];
            nxt_st.fp_out[i] = nxt_st.fpo_act[i]
                ^ nxt_st.ock_act[i][`TSCI_OC_FPLOW];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= `TSCI_STATE_RST;
        end else begin
            st <= nxt_st;
        end
    end

    assign serial_out_primary = st.oa;
    assign serial_out_primary_oe = st.oe_a;
    assign serial_out_secondary = st.ob;
    assign serial_out_secondary_oe = st.oe_b;
    assign timing_clock_out = st.ck_out;
    assign timing_frame_pulse_out = st.fp_out;
    assign reg_rdata = st.rdata;

    // checks
    logic [`TSCI_GROUPS-1:0] fast_out;
    logic fast_in3;
    logic int_top0;

    always_comb begin
        for (int g = 0; g < `TSCI_GROUPS; g++) begin
            fast_out[g] = st.out_act[g][`TSCI_F_RATE] == `TSCI_RATE_FAST;
        end
        // group 3 is the one that runs at the top rate in use
        fast_in3 = st.in_act[3][`TSCI_F_RATE] == `TSCI_RATE_FAST;
        int_top0 = st.ock_act[0][`TSCI_OC_INT]
            && st.ock_act[0][`TSCI_F_RATE] == `TSCI_RATE_FAST;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_gate_drops_oe: assert property (
        !st.gate_s[1] |=> (st.oe_a == '0) && (st.oe_b == '0))
        else $error("outputs still enabled after gate low");

    a_fast_b_idle: assert property (
        (st.oe_b & fast_out) == '0)
        else $error("b output driven at top rate");

    a_fast_b_ignored: assert property (
        $rose(st.pending[3]) && fast_in3 |-> st.hold_b[3] == 8'h00)
        else $error("b input taken at top rate");

    a_cfg_at_frame: assert property (
        $changed(st.in_act) || $changed(st.out_act)
        |-> $past(frame_now))
        else $error("group setting changed outside a frame");

    a_fpo_width: assert property (
        $rose(st.fpo_act[0]) && int_top0
        |-> st.fpo_act[0] [*2] ##1 !st.fpo_act[0])
        else $error("frame pulse out width wrong");

    a_fpo_level: assert property (
        st.fp_out[0] == (st.fpo_act[0] ^ st.ock_act[0][`TSCI_OC_FPLOW]))
        else $error("frame pulse out level wrong");

    a_sel_follow: assert property (
        !$past(rst) && !$past(rst, 2)
        |-> st.sel_s[3:2] == $past(master_rate_select, 2))
        else $error("rate select not tracked");

    a_frame_restart: assert property (
        frame_now |=> st.edge_cnt == `TSCI_CNT_W'(1))
        else $error("frame did not restart count");

    a_fp_polarity: assert property (
        edge_now && (st.fp_s[1] ^ st.in_clk_act[`TSCI_F_FPLOW])
        |-> frame_now ##1 st.frame_seen)
        else $error("frame pulse missed");

endmodule : tsci_stream_core

// >>> sim/tsci_far_end.sv
`timescale 1ns/1ps
module tsci_far_end
    import tsci_pkg::*;
#(
    parameter int FRAME_EDGES = 64
)
(
    input wire logic run,
    input wire logic [31:0][7:0] byte_a,
    input wire logic [31:0][7:0] byte_b,
    output logic ck,
    output logic fp,
    output logic [31:0] sa,
    output logic [31:0] sb
);
    int n;
    initial begin
        ck = 1'b0;
        fp = 1'b0;
        sa = '0;
        sb = '0;
        n = 0;
        forever begin
            // data moves in the low half so it is settled at the rise
            if (run) begin
                fp = (n % FRAME_EDGES) == 0;
                for (int g = 0; g < 32; g++) begin
                    sa[g] = byte_a[g][7 - n % 8];
                    sb[g] = byte_b[g][7 - n % 8];
                end
                n++;
            end
            #200 ck = run;
            #200 ck = 1'b0;
        end
    end
endmodule : tsci_far_end

// >>> sim/tsci_stream_core_test.sv
`timescale 1ns/1ps
`include "tsci_regs.svh"
module tsci_stream_core_test
    import tsci_pkg::*;
    ;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] sel = 2'h0;
    logic gate = 1'b1;
    logic run = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rx_ready = 1'b1;
    logic chk_rx = 1'b0;
    logic [31:0] seen = '0;
    logic ck, fp, rx_valid;
    logic [31:0] sa, sb, oa, oa_oe, ob, ob_oe, rdata;
    logic [1:0] tck, tfp;
    logic [31:0][7:0] ba, bb;
    tsci_rx_word_type rx_word;
    int in_rate[32];
    int in_inv[32];
    int error_cnt = 0;
    int compares = 0;
    wire [3:0] tsig = {tfp, tck};

    always #25 ref_clk = ~ref_clk;

    tsci_stream_core uut (
        .ref_clk(ref_clk),
        .rst(rst),
        .master_tdm_clock_in(ck),
        .master_frame_pulse_in(fp),
        .master_rate_select(sel),
        .stream_output_gate(gate),
        .serial_in_primary(sa),
        .serial_in_secondary(sb),
        .serial_out_primary(oa),
        .serial_out_primary_oe(oa_oe),
        .serial_out_secondary(ob),
        .serial_out_secondary_oe(ob_oe),
        .timing_clock_out(tck),
        .timing_frame_pulse_out(tfp),
        .reg_addr(addr),
        .reg_wdata(wdata),
        .reg_wr(wr),
        .reg_rd(rd),
        .reg_rdata(rdata),
        .rx_valid(rx_valid),
        .rx_ready(rx_ready),
        .rx_word(rx_word)
    );

    tsci_far_end far (
        .run(run),
        .byte_a(ba),
        .byte_b(bb),
        .ck(ck),
        .fp(fp),
        .sa(sa),
        .sb(sb)
    );

    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check_val(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        d = rdata;
    endtask : reg_read

    // bounded wait for a level, then count how long it holds
    task automatic run_len(input int i, input logic lvl, output int n);
        int k;
        n = 0;
        for (k = 0; k < 3000 && tsig[i] === lvl; k++) @(posedge ref_clk);
        for (k = 0; k < 3000 && tsig[i] !== lvl; k++) @(posedge ref_clk);
        while (n < 3000 && tsig[i] === lvl) begin
            n++;
            @(posedge ref_clk);
        end
        if (k >= 3000 || n >= 3000) begin
            error_cnt++;
            $display("ERROR timing output %0d wait ran out", i);
            stop_test();
        end
    endtask : run_len

    function automatic logic [15:0] exp_in(input int g);
        logic [7:0] a, b;
        a = in_inv[g] != 0 ? ~ba[g] : ba[g];
        b = in_rate[g] == 3 ? 8'h00 : (in_inv[g] != 0 ? ~bb[g] : bb[g]);
        return {b, a};
    endfunction : exp_in

    // bytes repeat every slot, so any word popped must match its group
    function automatic logic is_rot(input logic [7:0] v,
            input logic [7:0] p);
        is_rot = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (v === 8'({p, p} >> i)) is_rot = 1'b1;
        end
    endfunction : is_rot

    always @(posedge ref_clk) begin
        if (chk_rx && rx_valid === 1'b1 && rx_ready === 1'b1) begin
            seen[rx_word.group] <= 1'b1;
            check_val("rx word", {11'h0, rx_word.group,
                exp_in(int'(rx_word.group))}, {11'h0, rx_word});
        end
    end

    initial begin
        logic [31:0] d;
        logic [7:0] s5, s6, s7;
        logic [7:0] ra[6];
        int n;
        ra = '{8'h00, 8'h20, 8'h40, 8'h41, 8'h42, 8'h50};
        void'($urandom(32'h0716));
        for (int g = 0; g < 32; g++) begin
            ba[g] = 8'($urandom);
            bb[g] = 8'($urandom);
            in_rate[g] = 0;
            in_inv[g] = 0;
        end
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            reg_read(ra[i], d);
            check_val("reset value", 32'h0, d);
        end
        reg_write(8'h50, 32'hffffffff);
        reg_read(8'h50, d);
        check_val("unmapped", 32'h0, d);
        for (int k = 0; k < 4; k++) begin
            in_rate[k] = k;
            in_inv[k] = (k == 1);
            reg_write(8'(k), 32'(k + 4 * in_inv[k]));
            reg_write(8'(8'h20 + k), 32'h0700 + 32'(k));
            reg_read(8'(k), d);
            check_val("group setting", 32'(k + 4 * in_inv[k]), d & 32'h7);
        end
        reg_write(8'h25, 32'h0700);
        reg_write(8'h26, 32'h5a_0704);
        run <= 1'b1;
        repeat (1600) @(posedge ref_clk);
        chk_rx <= 1'b1;
        repeat (600) @(posedge ref_clk);
        for (int k = 0; k < 4; k++) begin
            reg_read(8'(k), d);
            check_val("last bytes", {8'h0, exp_in(k), 8'h0},
                d & 32'hffff00);
        end
        reg_read(8'h42, d);
        check_val("frame seen", 32'h4, d & 32'h4);
        check_val("oe a", 32'hffffffff, oa_oe);
        check_val("oe b", 32'hfffffff7, ob_oe);
        for (int i = 0; i < 8; i++) begin
            repeat (8) @(posedge ref_clk);
            s5 = {s5[6:0], oa[5]};
            s6 = {s6[6:0], oa[6]};
            s7 = {s7[6:0], ob[6]};
        end
        check_val("out plain", 32'h1, 32'(is_rot(s5, 8'h07)));
        check_val("out inverted", 32'h1, 32'(is_rot(s6, 8'hf8)));
        check_val("out b inverted", 32'h1, 32'(is_rot(s7, 8'ha5)));
        rx_ready <= 1'b0;
        repeat (200) @(posedge ref_clk);
        check_val("stalled valid", 32'h1, 32'(rx_valid));
        reg_read(8'h42, d);
        check_val("overrun", 32'h8, d & 32'h8);
        rx_ready <= 1'b1;
        repeat (100) @(posedge ref_clk);
        reg_write(8'h42, 32'h8);
        reg_read(8'h42, d);
        check_val("overrun clear", 32'h0, d & 32'h8);
        gate <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check_val("oe off", 32'h0, oa_oe | ob_oe);
        gate <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            reg_write(8'h41, 32'h18 + 32'(c));
            repeat (1200) @(posedge ref_clk);
            run_len(0, 1'b1, n);
            check_val("clock half", 32'(2 ** (3 - c)), 32'(n));
            run_len(2, 1'b0, n);
            check_val("pulse width", 32'(2 ** (4 - c)), 32'(n));
            run_len(1, 1'b1, n);
            check_val("master clock half", 32'h4, 32'(n));
        end
        // clock 1 inverted: it stands high in the cycle the pulse ends
        reg_write(8'h41, 32'h0400);
        repeat (1200) @(posedge ref_clk);
        run_len(3, 1'b1, n);
        check_val("pulse width 1", 32'h8, 32'(n));
        check_val("clock 1 inverted", 32'h1, 32'(tck[1]));
        check_val("groups seen", 32'hffffffff, seen);
        // the far end keeps its rate, so received words stop matching
        chk_rx <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            sel <= 2'(s);
            repeat (4) @(posedge ref_clk);
            reg_read(8'h42, d);
            check_val("rate select", 32'(s), d & 32'h3);
        end
        stop_test();
    end
endmodule : tsci_stream_core_test
